// ### hw/spice_core.sv
// serial control register, master/slave shifter and select expander
`include "spice_map.svh"
module spice_core
  import spice_pkg::*;
#(
  parameter int DIV_FAST    = `SPICE_DIV_FAST,
  parameter int DIV_STD     = `SPICE_DIV_STD,
  parameter int DIV_SLOW    = `SPICE_DIV_SLOW,
  parameter int FRAME_BYTES = `SPICE_FRAME_BYTES
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_event,
  input  wire logic       tx_event,
  output logic            rx_irq,
  output logic            tx_irq,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       ss_n_in,
  output logic            ss_n_out,
  output logic            ss_n_oe,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe,
  input  wire logic [7:0] expander_bit_select,
  input  wire logic [7:0] port_gpio_out,
  output logic      [7:0] port_out,
  output logic      [7:0] extra_select_outputs,
  output logic            expander_detected
);
  initial begin
    if (DIV_FAST < 2 || DIV_STD < 2 || DIV_SLOW < 2 || FRAME_BYTES < 1
        || FRAME_BYTES > 16 || DIV_FAST > DIV_SLOW || DIV_STD > DIV_SLOW)
      $error("spice_core: bad divider or frame size");
  end

  localparam int CW = $clog2(DIV_SLOW) + 1;

  // control register fields
  logic [7:0]   serial_control_r;
  wire          rx_irq_enable     = serial_control_r[`SPICE_B_RXIE];
  wire          tx_irq_enable     = serial_control_r[`SPICE_B_TXIE];
  wire          expander_enable   = serial_control_r[`SPICE_B_EXPEN];
  wire          clock_edge_select = serial_control_r[`SPICE_B_EDGE];
  wire          interface_enable  = serial_control_r[`SPICE_B_EN];
  wire          loopback_enable   = serial_control_r[`SPICE_B_LOOP];
  spice_mode_e  role_and_rate_select;
  assign role_and_rate_select = spice_mode_e'(
    serial_control_r[`SPICE_B_MODE_HI:`SPICE_B_MODE_LO]);
  wire          is_master = role_and_rate_select != SPICE_SLAVE; // RQ10
  wire          ctrl_hit  = reg_wr && reg_addr == `SPICE_CTRL_ADDR;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      serial_control_r <= `SPICE_CTRL_RESET;
    else if (clk_en && ctrl_hit)
      serial_control_r <= reg_wdata;
  end
  assign reg_rdata = (reg_addr == `SPICE_CTRL_ADDR) ? serial_control_r : 8'h00;

  // interrupt gating; events come from the status logic elsewhere
  assign rx_irq = rx_event && rx_irq_enable; // RQ1 RQ2
  assign tx_irq = tx_event && tx_irq_enable; // RQ3

  // pin synchronisers: three stages, change counts when 2 and 3 agree
  logic [2:0] sck_s_r, ss_s_r, mosi_s_r, miso_s_r;
  logic       sck_f_r, ss_f_r, mosi_f_r, miso_f_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck_s_r  <= 3'h0;
      ss_s_r   <= 3'h7;
      mosi_s_r <= 3'h7;
      miso_s_r <= 3'h7;
      sck_f_r  <= 1'b0;
      ss_f_r   <= 1'b1;
      mosi_f_r <= 1'b1;
      miso_f_r <= 1'b1;
    end else if (clk_en) begin
      sck_s_r  <= {sck_s_r[1:0], sck_in};
      ss_s_r   <= {ss_s_r[1:0], ss_n_in};
      mosi_s_r <= {mosi_s_r[1:0], mosi_in};
      miso_s_r <= {miso_s_r[1:0], miso_in};
      if (sck_s_r[1] == sck_s_r[2])   sck_f_r  <= sck_s_r[2];
      if (ss_s_r[1] == ss_s_r[2])     ss_f_r   <= ss_s_r[2];
      if (mosi_s_r[1] == mosi_s_r[2]) mosi_f_r <= mosi_s_r[2];
      if (miso_s_r[1] == miso_s_r[2]) miso_f_r <= miso_s_r[2];
    end
  end

  // master clock generator; half period is divider over two
  function automatic logic [CW-1:0] half_div(input spice_mode_e m);
    unique case (m)
      SPICE_FAST: half_div = CW'(DIV_FAST / 2);
      SPICE_STD:  half_div = CW'(DIV_STD / 2);
      SPICE_SLOW: half_div = CW'(DIV_SLOW / 2);
      SPICE_SLAVE: half_div = CW'(DIV_FAST / 2);
    endcase
  endfunction

  spice_state_e state_r;
  logic [CW-1:0] div_r;
  logic          msck_r;     // master serial clock level
  logic          mss_n_r;    // master select level
  logic          stop_r;     // frame ends at the next half tick
  logic [2:0]    bit_r;
  logic [3:0]    byte_r;
  logic [7:0]    shift_r;
  logic          dout_r;     // launched data bit
  logic          sck_prev_r, ss_prev_r;
  logic          exp_mode_r, first_done_r;
  logic [7:0]    ess_r;
  logic [7:0]    rx_data_r;
  logic          rx_valid_r;

  wire half_tick = is_master && state_r == SPICE_SHIFT
                   && div_r == half_div(role_and_rate_select) - CW'(1); // RQ11
  // effective select and clock seen by the shifter
  wire cur_sck  = is_master ? msck_r  : sck_f_r;                        // RQ9
  wire cur_ss_n = is_master ? mss_n_r : ss_f_r;
  wire sck_rise = interface_enable && cur_sck && !sck_prev_r;
  wire sck_fall = interface_enable && !cur_sck && sck_prev_r;
  wire ss_fall  = interface_enable && !cur_ss_n && ss_prev_r;
  wire ss_rise  = interface_enable && cur_ss_n && !ss_prev_r;
  wire sample_e = clock_edge_select ? sck_fall : sck_rise;              // RQ12 RQ13
  wire launch_e = clock_edge_select ? sck_rise : sck_fall;              // RQ12 RQ13
  // data in: loopback takes our own output, else the role's input pin
  wire din = loopback_enable ? dout_r                                   // RQ16 RQ17
           : (is_master ? miso_f_r : mosi_f_r);                         // RQ9 RQ10
  wire [7:0] shifted = {shift_r[6:0], din};
  wire       byte_done = sample_e && bit_r == 3'h7;
  assign tx_ready = interface_enable && !cur_ss_n && byte_done;

  // master frame sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= SPICE_IDLE;
      div_r   <= '0;
      msck_r  <= 1'b0;
      mss_n_r <= 1'b1;
      stop_r  <= 1'b0;
    end else if (clk_en) begin
      unique case (state_r)
        SPICE_IDLE: begin
          msck_r <= clock_edge_select;
          div_r  <= '0;
          stop_r <= 1'b0;
          if (is_master && interface_enable && tx_valid) begin
            mss_n_r <= 1'b0;
            state_r <= SPICE_SHIFT;
          end
        end
        SPICE_SHIFT: begin
          div_r <= half_tick ? '0 : div_r + CW'(1);
          if (half_tick) msck_r <= !msck_r;
          // last byte: finish the running half period, no runt clock
          if (byte_done && (!tx_valid || byte_r == 4'(FRAME_BYTES - 1)))
            stop_r <= 1'b1;                                          // RQ18
          if (!interface_enable || !is_master || (stop_r && half_tick))
            state_r <= SPICE_END;                                    // RQ11
        end
        SPICE_END: begin
          mss_n_r <= 1'b1;
          msck_r  <= clock_edge_select;
          state_r <= SPICE_IDLE;
        end
      endcase
    end
  end

  // shifter, byte count and expander decision
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck_prev_r   <= 1'b0;
      ss_prev_r    <= 1'b1;
      bit_r        <= 3'h0;
      byte_r       <= 4'h0;
      shift_r      <= 8'h00;
      dout_r       <= 1'b1;
      exp_mode_r   <= 1'b0;
      first_done_r <= 1'b0;
      ess_r        <= `SPICE_ALL_ONES;
      rx_data_r    <= 8'h00;
      rx_valid_r   <= 1'b0;
    end else if (clk_en) begin
      sck_prev_r <= cur_sck;
      ss_prev_r  <= cur_ss_n;
      rx_valid_r <= 1'b0;
      if (!interface_enable)
        ess_r <= `SPICE_ALL_ONES;                                    // RQ14
      if (ctrl_hit && reg_wdata[`SPICE_B_EN])
        ess_r <= `SPICE_ALL_ONES;                                    // RQ15
      if (ss_fall) begin
        bit_r        <= 3'h0;
        byte_r       <= 4'h0;
        first_done_r <= 1'b0;
        exp_mode_r   <= expander_enable && !din;                     // RQ4 RQ19
        shift_r      <= tx_data;
        dout_r       <= tx_data[7];
      end else if (ss_rise) begin
        exp_mode_r <= 1'b0;                                          // RQ19
        ess_r      <= `SPICE_ALL_ONES;                               // RQ7
      end else if (!cur_ss_n) begin
        if (sample_e) begin
          bit_r   <= bit_r + 3'h1;
          shift_r <= shifted;
          if (byte_done) begin
            byte_r <= byte_r + 4'h1;
            if (exp_mode_r && !first_done_r) begin
              ess_r        <= shifted;                               // RQ5
              first_done_r <= 1'b1;
            end else if (!exp_mode_r) begin                          // RQ6
              rx_data_r  <= shifted;
              rx_valid_r <= 1'b1;
            end
          end
        end
        if (launch_e) begin
          if (bit_r == 3'h0) begin
            shift_r <= tx_data;
            dout_r  <= tx_data[7];
          end else
            dout_r <= shift_r[7];
        end
      end
    end
  end

  assign rx_data  = rx_data_r;
  assign rx_valid = rx_valid_r;
  assign expander_detected = exp_mode_r && first_done_r;
  assign extra_select_outputs = ess_r;

  // pin drivers; loopback keeps the data output off the pins
  assign sck_out  = msck_r;
  assign sck_oe   = interface_enable && is_master;                   // RQ10 RQ14
  assign ss_n_out = mss_n_r;
  assign ss_n_oe  = interface_enable && is_master;
  assign mosi_out = dout_r;
  assign mosi_oe  = interface_enable && is_master && !loopback_enable;
  assign miso_out = dout_r;
  assign miso_oe  = interface_enable && !is_master                   // RQ9
                    && !ss_f_r && !loopback_enable;
  // per-bit mux: expander bit or general purpose
  assign port_out = (expander_bit_select & ess_r)
                  | (~expander_bit_select & port_gpio_out);          // RQ8
endmodule

// ### pkg/spice_map.svh
// register offsets, field positions and timing counts for the serial control block
//
// Contract
// RQ1: receive interrupt gated by control bit 7
// RQ2: receive interrupt only when enable is one
// RQ3: transmit interrupt gated by control bit 6
// RQ4: expander disabled ignores data-in at select fall
// RQ5: first byte drives expander port when armed
// RQ6: later bytes in expander frame are discarded
// RQ7: expander outputs forced high at select rise
// RQ8: only selected port bits act as expander
// RQ9: mode 00 is slave, pins as inputs
// RQ10: nonzero mode is master, drives clock, select
// RQ11: master clock divides by 10, 40, 160
// RQ12: edge select clear: launch fall, sample rise
// RQ13: edge select set: launch rise, sample fall
// RQ14: interface and pins enabled only by bit 1
// RQ15: enabling interface drives expander outputs high
// RQ16: loopback bit ties data out to data in
// RQ17: loopback passes transmit data to receive side
// RQ18: frame spans select fall to rise, 12 bytes
// RQ19: expander decision latched per frame
`ifndef SPICE_MAP_SVH
`define SPICE_MAP_SVH
`define SPICE_CTRL_ADDR   8'h98
`define SPICE_CTRL_RESET  8'h00
`define SPICE_B_RXIE      7
`define SPICE_B_TXIE      6
`define SPICE_B_EXPEN     5
`define SPICE_B_MODE_HI   4
`define SPICE_B_MODE_LO   3
`define SPICE_B_EDGE      2
`define SPICE_B_EN        1
`define SPICE_B_LOOP      0
`define SPICE_DIV_FAST    10
`define SPICE_DIV_STD     40
`define SPICE_DIV_SLOW    160
`define SPICE_FRAME_BYTES 12
`define SPICE_ALL_ONES    8'hff
`endif

// ### pkg/spice_pkg.sv
// types shared by the serial control block
package spice_pkg;
  typedef enum logic [1:0] {
    SPICE_SLAVE = 2'h0,
    SPICE_FAST  = 2'h1,
    SPICE_STD   = 2'h2,
    SPICE_SLOW  = 2'h3
  } spice_mode_e;
  typedef enum {
    SPICE_IDLE,
    SPICE_SHIFT,
    SPICE_END
  } spice_state_e;
endpackage

// ### verif/spi_control_and_select_expander_tb_top.sv
// self-checking bench for the serial control block
`include "spice_map.svh"
module spi_control_and_select_expander_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk, rst, reg_wr, tx_valid, tx_ready, rx_valid, go, lv;
  logic       rx_event, tx_event, det, busy, lead, lp, m_sck, m_ss, m_mosi;
  logic       sck_out, sck_oe, ss_n_out, ss_n_oe, mosi_out, mosi_oe, miso_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_data, rx_data, rx_last;
  logic [7:0] bsel, gpio, ess, b0, so_cap;
  logic [3:0] nb;
  logic [1:0] m;
  int         fails, check_count, rx_cnt, seed, hi;
  // pin levels resolved from the core's enables, else the model drives
  wire sck_in = sck_oe ? sck_out : m_sck;
  wire ss_n_in = ss_n_oe ? ss_n_out : m_ss;
  wire mosi_in = mosi_oe ? mosi_out : m_mosi;
  wire miso_in = ~mosi_out; // inverting echo, so pins and loop differ
  spice_core u_spice_core (
    .ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rdata(reg_rdata), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_event(rx_event), .tx_event(tx_event), .rx_irq(), .tx_irq(),
    .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
    .ss_n_in(ss_n_in), .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe),
    .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_in), .miso_out(miso_q), .miso_oe(),
    .expander_bit_select(bsel), .port_gpio_out(gpio), .port_out(),
    .extra_select_outputs(ess), .expander_detected(det));
  spice_master_model u_spice_master_model (.clk(ref_clk), .go(go),
    .lead(lead), .b0(b0), .nb(nb), .ss_n(m_ss), .sck(m_sck),
    .mosi(m_mosi), .busy(busy));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic int half_of(logic [1:0] md);
    return md == 2'h1 ? `SPICE_DIV_FAST / 2 :
           md == 2'h2 ? `SPICE_DIV_STD / 2 : `SPICE_DIV_SLOW / 2;
  endfunction
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude();
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task wr(input logic [7:0] d);
    reg_addr = `SPICE_CTRL_ADDR;
    reg_wdata = d;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask
  // received bytes are counted and the last one kept
  always @(posedge ref_clk) begin
    if (rx_valid === 1'b1) begin
      rx_cnt++;
      rx_last = rx_data;
    end
  end
  // slave data as the far side sees it at each clock rise
  always @(posedge m_sck) so_cap = {so_cap[6:0], miso_q};
  // random events and port inputs every cycle
  always @(posedge ref_clk) begin
    #1;
    {rx_event, tx_event} = 2'($random(seed));
    {bsel, gpio} = 16'($random(seed));
  end
  initial begin
    #(30000 * 8);
    fails++;
    conclude();
  end
  initial begin
    seed = 80;
    {fails, check_count, rx_cnt} = '0;
    {rst, reg_wr, tx_valid, go, lead, rx_event, tx_event} = 7'h41;
    {reg_addr, reg_wdata, tx_data, b0, bsel, gpio} = {8'h98, 40'h0};
    nb = 4'h2;
    repeat (12) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk(reg_rdata, `SPICE_CTRL_RESET);
    chk(ess, 8'hff);
    reg_addr = 8'h99;
    step(1);
    chk(reg_rdata, 8'h00);
    wr(8'hc0);
    chk(reg_rdata, 8'hc0);
    // slave frames: expander off, on with high lead, on and armed
    for (int i = 0; i < 3; i++) begin
      wr(i == 0 ? 8'h02 : 8'h22);
      b0 = 8'($random(seed));
      tx_data = 8'($random(seed));
      lead = (i == 1);
      rx_cnt = 0;
      go = 1'b1;
      step(1);
      go = 1'b0;
      for (int n = 0; n < 900 && busy === 1'b1 && det !== 1'b1; n++) step(1);
      if (i == 2) chk(ess, b0);
      for (int n = 0; n < 900 && busy === 1'b1; n++) step(1);
      step(8);
      chk(8'(rx_cnt), i == 2 ? 8'h00 : 8'h02);
      if (i < 2) chk(rx_last, ~b0);
      chk(so_cap, tx_data);
      chk(ess, 8'hff);
    end
    // master at each rate and edge, last pass in loop-back
    for (int i = 0; i < 4; i++) begin
      m = (i == 3) ? 2'h1 : 2'(i + 1);
      lp = (i == 3);
      wr({3'h0, m, 1'(i), 1'b1, lp});
      tx_data = 8'($random(seed));
      lv = sck_out; // idle level, so the first phase is measured whole
      tx_valid = 1'b1;
      for (int n = 0; n < 400 && sck_out === lv; n++) step(1);
      hi = 0;
      for (int n = 0; n < 400 && sck_out !== lv; n++) begin
        step(1);
        hi++;
      end
      if (!lp) chk(8'(hi), 8'(half_of(m)));
      for (int n = 0; n < 3000 && tx_ready !== 1'b1; n++) step(1);
      tx_valid = 1'b0;
      step(400);
      chk(rx_last, lp ? tx_data : ~tx_data);
    end
    wr(8'h00);
    step(4);
    conclude();
  end
endmodule

// ### verif/spice_core_asserts.sv
// port checker for the serial control block
`include "spice_map.svh"
module spice_core_asserts
  import spice_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic       rx_event,
  input wire logic       tx_event,
  input wire logic       rx_irq,
  input wire logic       tx_irq,
  input wire logic       sck_out,
  input wire logic       sck_oe,
  input wire logic       ss_n_out,
  input wire logic       ss_n_in,
  input wire logic       ss_n_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic [7:0] expander_bit_select,
  input wire logic [7:0] port_gpio_out,
  input wire logic [7:0] port_out,
  input wire logic [7:0] extra_select_outputs
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // control value is only visible while addressed
  wire       sel = reg_addr == `SPICE_CTRL_ADDR;
  wire [7:0] c = reg_rdata;
  wire       en = sel && c[`SPICE_B_EN];
  wire       slave = en && c[4:3] == 2'h0;
  wire       master = en && c[4:3] != 2'h0 && !c[`SPICE_B_LOOP];
  // fast clock inside a frame: rise, four more high cycles, then low
  sequence fast_rise;
    master && c[4:3] == 2'h1 && $rose(sck_out);
  endsequence
  sequence half_hi;
    sck_out [*4] ##1 !sck_out;
  endsequence
  a_rx_gate: assert property (
    sel |-> rx_irq == (rx_event && c[7])) else $error("rx irq gate");
  a_tx_gate: assert property (
    sel |-> tx_irq == (tx_event && c[6])) else $error("tx irq gate");
  a_unmapped_zero: assert property (
    !sel |-> reg_rdata == 8'h00) else $error("unmapped read");
  // two cycles, though pin enables follow the register in the same cycle
  a_pins_off: assert property ((sel && !c[1]) [*2] |->
    !(sck_oe || ss_n_oe || mosi_oe || miso_oe)) else $error("pins on");
  a_slave_pins: assert property (slave [*2] |->
    !sck_oe && !ss_n_oe && !mosi_oe) else $error("slave pins");
  a_master_pins: assert property (master [*2] |->
    sck_oe && ss_n_oe && mosi_oe && !miso_oe) else $error("master pins");
  a_fast_half: assert property (
    fast_rise ##1 !ss_n_out |-> half_hi)
    else $error("fast clock half period");
  a_ess_release: assert property ($rose(ss_n_in) |->
    ##[1:6] extra_select_outputs == 8'hff) else $error("ess not high");
  a_enable_ess: assert property (
    reg_wr && clk_en && sel && reg_wdata[1] |=>
    extra_select_outputs == `SPICE_ALL_ONES) else $error("enable ess");
  a_port_mux: assert property (
    port_out == (expander_bit_select & extra_select_outputs |
    ~expander_bit_select & port_gpio_out)) else $error("port mux");
endmodule
bind spice_core spice_core_asserts u_spice_core_asserts (.*);

// ### verif/spice_master_model.sv
// behavioural external master sending slave frames
module spice_master_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       lead,
  input  wire logic [7:0] b0,
  input  wire logic [3:0] nb,
  output logic            ss_n,
  output logic            sck,
  output logic            mosi,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  // slow half period leaves room for the pin synchronisers
  task automatic half();
    repeat (8) @(posedge clk);
  endtask
  // first byte b0, later bytes inverted, msb first
  task automatic frame();
    logic [7:0] d;
    busy <= 1'b1;
    mosi <= lead;
    half();
    ss_n <= 1'b0;
    half();
    for (int i = 0; i < nb; i++) begin
      d = (i == 0) ? b0 : ~b0;
      for (int k = 7; k >= 0; k--) begin
        mosi <= d[k];
        half();
        sck <= 1'b1;
        half();
        sck <= 1'b0;
      end
    end
    half();
    ss_n <= 1'b1;
    mosi <= ~mosi; // released line keeps no stale level
    busy <= 1'b0;
  endtask
  initial begin
    ss_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b1;
    busy = 1'b0;
  end
  always @(posedge clk) begin
    if (go && !busy) begin
      frame();
    end
  end
endmodule
